// ===== design/cifv_irq.sv
// CAN interrupt flags, enables and vector register
// Behaviour
// - Enable bits gate each source's request
// - Invalid message sets flag bit 15
// - Bus wake-up activity sets flag bit 14
// - Bus protocol error sets flag bit 13
// - System bus access failure sets bit 12
// - System error cleared only by enable toggle
// - Receive overflow sets flag bit 11
// - Mode reached request sets flag bit 3
// - Timestamp timer wrap sets flag bit 2
// - Bit 1 follows any receive buffer pending
// - Bit 0 follows any transmit buffer pending
// - Unused interrupt bits read zero, ignore writes
// - Vector bits 12:8 report matched filter
// - Source number 1000000 when nothing pending
// - Lowest pending FIFO n gives source number n
// - Module events use fixed codes 1000001-1001000
// - Disabled sources never appear in vector
`timescale 1ns/10ps
`default_nettype none
module cifv_irq (
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst_b,
   // Register port
   input  wire logic [7:0]            regAddr,
   input  wire logic [31:0]           regWrData,
   input  wire logic                  regWrEn,
   input  wire logic                  regRdEn,
   output logic      [31:0]           regRdData,
   // Event pulses and levels from the CAN engine
   input  wire cifv_pkg::cifv_events_s canEvents,
   input  wire logic [31:0]           fifoPendingStatus,
   input  wire logic                  rxBufferPending,
   input  wire logic                  txBufferPending,
   input  wire logic [4:0]            matchedFilterNumber,
   input  wire logic                  engineBusy,
   // Outputs
   output logic                       moduleOn,
   output logic                       moduleActive,
   output logic                       irqRequest
);
   ////////////////////////////////////////////////////////////////////////
   // State
   logic [8:0]  enable_reg;
   logic [6:0]  flag_reg;      // IVR,WAK,BERR,SERR,ROVF,MOD,TMR
   logic [1:0]  bufFlag_reg;   // RB,TB
   logic        on_reg;
   logic        active_reg;
   logic [6:0]  srcNum_reg;
   logic [4:0]  filt_reg;
   logic        irq_reg;
   logic [31:0] rdData_reg;
   // Remembers which kind of system error set bit 12, for the vector code
   logic        serrBw_reg;

   ////////////////////////////////////////////////////////////////////////
   // Decode
   wire wrIrq  = regWrEn && (regAddr == cifv_pkg::IRQ_REG_ADDR);
   wire wrCtrl = regWrEn && (regAddr == cifv_pkg::CTRL_REG_ADDR);
   // Re-enable edge is what releases the sticky system error
   wire turnOn = wrCtrl && regWrData[cifv_pkg::CTRL_ON] && !on_reg;

   // Event set terms
   wire [6:0] setVec = {canEvents.invalidMsg,
                        canEvents.wakeup,
                        canEvents.busError,
                        canEvents.addrError | canEvents.bandwidthError,
                        canEvents.rxOverflow,
                        canEvents.modeMatched,
                        canEvents.timerWrap};

   // Software may clear flags by writing zero; system error bit excluded
   wire [6:0] wrFlags = {regWrData[cifv_pkg::FL_IVR],
                         regWrData[cifv_pkg::FL_WAK],
                         regWrData[cifv_pkg::FL_BERR],
                         1'b1,
                         regWrData[cifv_pkg::FL_ROVF],
                         regWrData[cifv_pkg::FL_MOD],
                         regWrData[cifv_pkg::FL_TMR]};
   wire [6:0] keepVec = wrIrq ? (flag_reg & wrFlags) : flag_reg;
   // Set wins over clear in the same cycle
   wire [6:0] serrClr = turnOn ? 7'h08 : 7'h00;
   wire [6:0] flagNext = (keepVec & ~serrClr) | setVec;

   wire [8:0] enableNext = wrIrq ?
      {regWrData[31:27], regWrData[19:16]} : enable_reg;

   ////////////////////////////////////////////////////////////////////////
   // Enabled pending terms
   wire [8:0] flagsAll = {flag_reg[6:2], flag_reg[1:0], bufFlag_reg};
   wire [8:0] pendEn   = flagsAll & enable_reg;
   wire       anyPend  = |pendEn;

   // Lowest pending FIFO number
   logic [4:0] fifoIdx;
   logic       fifoAny;
   always_comb begin
      fifoIdx = 5'h00;
      fifoAny = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         if (fifoPendingStatus[i]) begin
            fifoIdx = 5'(i);
            fifoAny = 1'b1;
         end
      end
   end

   // Priority encode: module events first, then FIFOs
   logic [6:0] srcNext;
   always_comb begin
      srcNext = cifv_pkg::SRC_NONE;
      if (pendEn[8])
         srcNext = cifv_pkg::SRC_IVR;
      else if (pendEn[5] && serrBw_reg)
         srcNext = cifv_pkg::SRC_BW;
      else if (pendEn[5])
         srcNext = cifv_pkg::SRC_ADDR;
      else if (pendEn[6])
         srcNext = cifv_pkg::SRC_BERR;
      else if (pendEn[7])
         srcNext = cifv_pkg::SRC_WAK;
      else if (pendEn[4])
         srcNext = cifv_pkg::SRC_ROVF;
      else if (pendEn[3])
         srcNext = cifv_pkg::SRC_MOD;
      else if (pendEn[2])
         srcNext = cifv_pkg::SRC_TMR;
      else if ((pendEn[1] || pendEn[0]) && fifoAny)
         srcNext = {2'b00, fifoIdx};
   end

   // Register read mux
   wire [31:0] irqView = {enable_reg[8:4], 7'h00, enable_reg[3:0],
                          flag_reg[6:2], 7'h00, flag_reg[1:0],
                          bufFlag_reg};
   wire [31:0] vecView = {19'h00000, filt_reg, 1'b0, srcNum_reg};
   wire [31:0] ctrlView = {30'h0, active_reg, on_reg};
   wire [31:0] rdSel =
      (regAddr == cifv_pkg::IRQ_REG_ADDR)  ? irqView  :
      (regAddr == cifv_pkg::VEC_REG_ADDR)  ? vecView  :
      (regAddr == cifv_pkg::CTRL_REG_ADDR) ? ctrlView : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // Flags and enables
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         enable_reg  <= 9'h000;
         flag_reg    <= 7'h00;
         bufFlag_reg <= 2'b00;
      end else begin
         enable_reg  <= enableNext;
         flag_reg    <= flagNext;
         bufFlag_reg <= {rxBufferPending, txBufferPending};
      end
   end

   // Control, vector and outputs
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         on_reg       <= 1'b0;
         active_reg   <= 1'b0;
         srcNum_reg   <= cifv_pkg::SRC_NONE;
         filt_reg     <= 5'h00;
         irq_reg      <= 1'b0;
         rdData_reg   <= 32'h0000_0000;
         serrBw_reg   <= 1'b0;
      end else begin
         // The event pulse is gone once the flag shows, so keep its kind
         if (canEvents.bandwidthError)
            serrBw_reg <= 1'b1;
         else if (canEvents.addrError)
            serrBw_reg <= 1'b0;
         if (wrCtrl)
            on_reg <= regWrData[cifv_pkg::CTRL_ON];
         // Active lingers while the engine finishes its transaction
         active_reg   <= on_reg | engineBusy;
         srcNum_reg   <= srcNext;
         filt_reg     <= matchedFilterNumber;
         irq_reg      <= anyPend;
         rdData_reg   <= regRdEn ? rdSel : 32'h0000_0000;
      end
   end

   assign regRdData    = rdData_reg;
   assign moduleOn     = on_reg;
   assign moduleActive = active_reg;
   assign irqRequest   = irq_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_serrSet;
      canEvents.addrError;
   endsequence

   a_serr_sticky_write: assert property (
      flag_reg[3] && wrIrq && !turnOn |=> flag_reg[3])
      else $error("system error cleared by write");
   a_serr_set_event: assert property (
      s_serrSet |=> flag_reg[3])
      else $error("system error not set");
   a_ivr_set_event: assert property (
      canEvents.invalidMsg |=> flag_reg[6])
      else $error("invalid message flag not set");
   a_irq_out_follow: assert property (
      anyPend |=> irqRequest)
      else $error("irq request missing");
   a_irq_blocked_en: assert property (
      (enable_reg == 9'h000) |=> !irqRequest)
      else $error("irq with all enables off");
   a_src_none_idle: assert property (
      !anyPend |=> srcNum_reg == cifv_pkg::SRC_NONE)
      else $error("source number not none");
   a_src_not_reserved: assert property (
      !(srcNum_reg inside {[7'h20:7'h3F], [7'h49:7'h7F]}))
      else $error("reserved source number");
   a_src_ivr_first: assert property (
      pendEn[8] |=> srcNum_reg == cifv_pkg::SRC_IVR)
      else $error("invalid message priority lost");
   a_rb_follow_level: assert property (
      rxBufferPending |=> bufFlag_reg[1])
      else $error("rx buffer flag not following");
   a_unused_read_zero: assert property (
      regRdEn && regAddr == cifv_pkg::IRQ_REG_ADDR
      |=> (regRdData & ~cifv_pkg::IRQ_RW_MASK) == 32'h0)
      else $error("unused bits not zero");
endmodule : cifv_irq
`default_nettype wire

// ===== design/cifv_pkg.sv
// Package: register map, field positions and source codes for the CAN irq block
package cifv_pkg;
   // Register byte addresses (word aligned)
   localparam logic [7:0] IRQ_REG_ADDR  = 8'h00;
   localparam logic [7:0] VEC_REG_ADDR  = 8'h04;
   localparam logic [7:0] CTRL_REG_ADDR = 8'h08;
   // Enable field positions
   localparam int EN_IVR  = 31;
   localparam int EN_WAK  = 30;
   localparam int EN_BERR = 29;
   localparam int EN_SERR = 28;
   localparam int EN_ROVF = 27;
   localparam int EN_MOD  = 19;
   localparam int EN_TMR  = 18;
   localparam int EN_RB   = 17;
   localparam int EN_TB   = 16;
   // Flag field positions
   localparam int FL_IVR  = 15;
   localparam int FL_WAK  = 14;
   localparam int FL_BERR = 13;
   localparam int FL_SERR = 12;
   localparam int FL_ROVF = 11;
   localparam int FL_MOD  = 3;
   localparam int FL_TMR  = 2;
   localparam int FL_RB   = 1;
   localparam int FL_TB   = 0;
   // Implemented bits of the interrupt register
   localparam logic [31:0] IRQ_RW_MASK  = 32'hF80F_F80F;
   localparam logic [31:0] IRQ_RST      = 32'h0000_0000;
   // Vector field positions
   localparam int VEC_FILT_LSB = 8;
   // Control register: bit 0 module enable, bit 1 module active (read only)
   localparam int CTRL_ON     = 0;
   localparam int CTRL_ACTIVE = 1;
   // Source numbers
   localparam logic [6:0] SRC_NONE  = 7'h40;
   localparam logic [6:0] SRC_BERR  = 7'h41;
   localparam logic [6:0] SRC_WAK   = 7'h42;
   localparam logic [6:0] SRC_ROVF  = 7'h43;
   localparam logic [6:0] SRC_ADDR  = 7'h44;
   localparam logic [6:0] SRC_BW    = 7'h45;
   localparam logic [6:0] SRC_TMR   = 7'h46;
   localparam logic [6:0] SRC_MOD   = 7'h47;
   localparam logic [6:0] SRC_IVR   = 7'h48;
   // One cycle of event inputs from the CAN engine
   typedef struct packed {
      logic invalidMsg;
      logic wakeup;
      logic busError;
      logic addrError;
      logic bandwidthError;
      logic rxOverflow;
      logic modeMatched;
      logic timerWrap;
   } cifv_events_s;
endpackage : cifv_pkg

// ===== dv/cifv_engine_model.sv
// Stand-in for the CAN engine: event pulses and a busy tail after turn-off
`timescale 1ns/10ps
`default_nettype none
module cifv_engine_model #(
   parameter int BUSY_TAIL = 4
) (
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst_b,
   // Requests from the bench, state from the block
   input  wire logic [7:0]            eventReq,
   input  wire logic                  moduleOn,
   // Towards the block
   output var  cifv_pkg::cifv_events_s canEvents,
   output logic                       engineBusy
);
   logic [3:0] tailReg;
   ////////////////////////////////////////////////////////////////////////
   // One request cycle gives one event pulse, one cycle late like hardware
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         canEvents <= '0;
      end else begin
         canEvents <= cifv_pkg::cifv_events_s'(eventReq);
      end
   end
   // Engine keeps working a few cycles after turn-off, never stops at once
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tailReg <= 4'h0;
      end else if (moduleOn) begin
         tailReg <= 4'(BUSY_TAIL);
      end else if (tailReg != 4'h0) begin
         tailReg <= tailReg - 4'h1;
      end
   end
   assign engineBusy = (tailReg != 4'h0);
endmodule : cifv_engine_model
`default_nettype wire

// ===== dv/cifv_irq_test.sv
// Self-checking bench for the CAN interrupt flag and vector block
`timescale 1ns/10ps
`default_nettype none
module cifv_irq_test;
   logic core_clk, rst_b, regWrEn, regRdEn, rxBufferPending, txBufferPending;
   logic moduleOn, moduleActive, irqRequest, engineBusy;
   logic [7:0] regAddr, eventReq;
   logic [31:0] regWrData, regRdData, fifoPendingStatus, rd;
   logic [4:0] matchedFilterNumber;
   cifv_pkg::cifv_events_s canEvents;
   int errors = 0, samples_checked = 0, cycles = 0;
   ////////////////////////////////////////////////////////////////////////
   cifv_irq i_cifv_irq (.core_clk(core_clk), .rst_b(rst_b),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regRdData(regRdData), .canEvents(canEvents),
      .fifoPendingStatus(fifoPendingStatus), .rxBufferPending(rxBufferPending),
      .txBufferPending(txBufferPending), .engineBusy(engineBusy),
      .matchedFilterNumber(matchedFilterNumber), .moduleOn(moduleOn),
      .moduleActive(moduleActive), .irqRequest(irqRequest));
   cifv_engine_model i_cifv_engine_model (.core_clk(core_clk), .rst_b(rst_b),
      .eventReq(eventReq), .moduleOn(moduleOn), .canEvents(canEvents),
      .engineBusy(engineBusy));
   // Clock, and a hang guard well above the run length
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         complete_run();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regWrEn <= 1'b1; regAddr <= a; regWrData <= d;
      @(posedge core_clk);
      regWrEn <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rdr(input logic [7:0] a);
      @(posedge core_clk);
      regRdEn <= 1'b1; regAddr <= a;
      @(posedge core_clk);
      regRdEn <= 1'b0;
      #1 rd = regRdData;
   endtask : rdr
   task automatic pulse(input logic [7:0] v);
      @(posedge core_clk);
      eventReq <= v;
      @(posedge core_clk);
      eventReq <= 8'h00;
      repeat (3) @(posedge core_clk);
   endtask : pulse
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset_and_bits;
      rdr(cifv_pkg::IRQ_REG_ADDR); check(rd, 32'h0000_0000);
      rdr(cifv_pkg::VEC_REG_ADDR); check(rd, 32'h0000_0040);
      wr(cifv_pkg::IRQ_REG_ADDR, 32'hFFFF_FFFF);
      rdr(cifv_pkg::IRQ_REG_ADDR); check(rd, 32'hF80F_0000);
      rdr(8'h0C); check(rd, 32'h0000_0000);
      $display("test reset_and_bits done");
   endtask : t_reset_and_bits
   // Each module event except system error: its flag, its code, the request, then write-0 clear
   task automatic t_events;
      logic [7:0] ev[6] = '{8'h80, 8'h40, 8'h20, 8'h04, 8'h02, 8'h01};
      int fb[6] = '{15, 14, 13, 11, 3, 2};
      logic [6:0] cd[6] = '{7'h48, 7'h42, 7'h41, 7'h43, 7'h47, 7'h46};
      for (int i = 0; i < 6; i++) begin
         pulse(ev[i]);
         rdr(cifv_pkg::IRQ_REG_ADDR);
         check(rd, 32'hF80F_0000 | (32'h1 << fb[i]));
         check({31'h0, irqRequest}, 32'h1);
         rdr(cifv_pkg::VEC_REG_ADDR); check(rd, {25'h0, cd[i]});
         wr(cifv_pkg::IRQ_REG_ADDR, 32'hF80F_0000);
         repeat (2) @(posedge core_clk);
         check({31'h0, irqRequest}, 32'h0);
      end
      $display("test events done");
   endtask : t_events
   // System error survives a write, leaves only through an off/on toggle
   task automatic t_system_error;
      pulse(8'h10);
      wr(cifv_pkg::IRQ_REG_ADDR, 32'hF80F_0000);
      rdr(cifv_pkg::IRQ_REG_ADDR); check(rd, 32'hF80F_1000);
      rdr(cifv_pkg::VEC_REG_ADDR); check(rd, 32'h0000_0044);
      wr(cifv_pkg::CTRL_REG_ADDR, 32'h0);
      for (int n = 0; n < 20; n++) begin
         rdr(cifv_pkg::CTRL_REG_ADDR);
         if (rd[cifv_pkg::CTRL_ACTIVE] === 1'b0) break;
      end
      check(rd, 32'h0);
      wr(cifv_pkg::CTRL_REG_ADDR, 32'h1);
      rdr(cifv_pkg::IRQ_REG_ADDR); check(rd, 32'hF80F_0000);
      // Bandwidth kind of system error has its own code
      pulse(8'h08);
      rdr(cifv_pkg::VEC_REG_ADDR); check(rd, 32'h0000_0045);
      wr(cifv_pkg::CTRL_REG_ADDR, 32'h0);
      wr(cifv_pkg::CTRL_REG_ADDR, 32'h1);
      rdr(cifv_pkg::IRQ_REG_ADDR); check(rd, 32'hF80F_0000);
      $display("test system_error done");
   endtask : t_system_error
   // Disabled source, then buffer levels, lowest FIFO and filter number
   task automatic t_gating_fifo;
      wr(cifv_pkg::IRQ_REG_ADDR, 32'h0);
      pulse(8'h80);
      check({31'h0, irqRequest}, 32'h0);
      rdr(cifv_pkg::VEC_REG_ADDR); check(rd, 32'h0000_0040);
      wr(cifv_pkg::IRQ_REG_ADDR, 32'h0003_0000);
      fifoPendingStatus <= 32'h8000_0500;
      rxBufferPending <= 1'b1;
      matchedFilterNumber <= 5'h1F;
      repeat (3) @(posedge core_clk);
      rdr(cifv_pkg::IRQ_REG_ADDR); check(rd, 32'h0003_0002);
      rdr(cifv_pkg::VEC_REG_ADDR); check(rd, 32'h0000_1F08);
      wr(cifv_pkg::IRQ_REG_ADDR, 32'h8003_0000);
      pulse(8'h80);
      rdr(cifv_pkg::VEC_REG_ADDR); check(rd, 32'h0000_1F48);
      rxBufferPending <= 1'b0;
      txBufferPending <= 1'b1;
      repeat (3) @(posedge core_clk);
      rdr(cifv_pkg::IRQ_REG_ADDR); check(rd, 32'h8003_8001);
      $display("test gating_fifo done");
   endtask : t_gating_fifo
   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("Counts: %0d compared, %0d mismatched", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run
   // Main sequence: inputs idle at time zero, reset two cycles
   initial begin
      rst_b = 1'b0; regWrEn = 1'b0; regRdEn = 1'b0; regAddr = 8'h00;
      regWrData = 32'h0; eventReq = 8'h00; fifoPendingStatus = 32'h0;
      rxBufferPending = 1'b0; txBufferPending = 1'b0;
      matchedFilterNumber = 5'h00;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      t_reset_and_bits();
      wr(cifv_pkg::CTRL_REG_ADDR, 32'h1);
      t_events();
      t_system_error();
      t_gating_fifo();
      complete_run();
   end
endmodule : cifv_irq_test
`default_nettype wire
